// ===== tb/rsr_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "rsr_params.svh"

module rsr_regs_tb;
	logic core_clk, rst, ce, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] pstrb;
	logic [15:0] wakeTimer;
	logic [7:0] cal;
	logic [6:0] txc, rxc;
	logic crcDone, crcPass, rxEnter, pqm, sff, out2, out0, txu, rxo;
	logic csA, ccA, irq, legacy, pin2, pin0, crcExp;
	logic [32:0] expQ[$];
	logic [32:0] note;
	logic [32:0] pe;
	int miscompares = 0;
	int nChecks = 0;

	rsr_regs rsr_regs_inst (.core_clk(core_clk), .rst(rst), .ce(ce),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .wakeTimer(wakeTimer), .crcCheckDone(crcDone),
		.crcPass(crcPass), .rxEnter(rxEnter), .preambleQualityMet(pqm),
		.syncFoundFlag(sff), .generalOutputTwo(out2),
		.generalOutputZero(out0), .synthCalDac(cal), .txQueueCount(txc),
		.txQueueUnderrun(txu), .rxQueueCount(rxc), .rxQueueOverrun(rxo),
		.carrierSenseAsync(csA), .clearChannelAsync(ccA), .irq(irq),
		.legacyCrcModeEnable(legacy), .generalOutputTwoPin(pin2),
		.generalOutputZeroPin(pin0));

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	task completeRun;
		if (expQ.size() != 0) begin
			miscompares++;
			$display("MISMATCH %0t answers missing", $time);
		end
		$display("checks %0d mismatches %0d", nChecks, miscompares);
		if (miscompares == 0 && nChecks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : completeRun

	// the answer is noted before the request goes out; the monitor pairs them
	task apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
			input logic [32:0] ex);
		expQ.push_back(ex);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= wd;
		@(posedge core_clk);
		penable <= 1'b1;
		// no cycle count assumed; only the watchdog ends a hung wait
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task chk(input logic got, input logic ex);
		nChecks++;
		if (got !== ex) begin
			miscompares++;
			$display("MISMATCH %0t level %b expected %b", $time, got, ex);
		end
	endtask : chk

	always @(posedge core_clk) begin
		if (pready === 1'b1) begin
			nChecks++;
			if (expQ.size() == 0) begin
				miscompares++;
				$display("MISMATCH %0t answer with no request", $time);
			end else begin
				note = expQ.pop_front();
				if ({pslverr, prdata} !== note) begin
					miscompares++;
					$display("MISMATCH %0t got %h expected %h", $time,
						{pslverr, prdata}, note);
				end
			end
		end
	end

	initial begin
		repeat (20000) @(posedge core_clk);
		miscompares++;
		completeRun();
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		{rst, ce, pstrb} = 6'h3f;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{wakeTimer, cal, txc, rxc} = '0;
		{crcDone, crcPass, rxEnter, pqm, sff, out2, out0, txu, rxo} = '0;
		{csA, ccA, crcExp} = '0;
		void'($urandom(32'h9eea87b1));
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		for (int i = 0; i < 3; i++)
			apb(1'b0, 8'h40 + 8'(i), 32'h0, 33'h0);
		chk(irq, 1'b0);
		$display("test reset values done");

		repeat (4) begin
			@(posedge core_clk);
			wakeTimer <= 16'($urandom());
			cal <= 8'($urandom());
			{txu, txc, rxo, rxc} <= 16'($urandom());
			@(posedge core_clk);
			apb(1'b0, `RSR_IDX_WAKE_HI, 32'h0, {25'h0, wakeTimer[15:8]});
			apb(1'b0, `RSR_IDX_WAKE_LO, 32'h0, {25'h0, wakeTimer[7:0]});
			apb(1'b0, `RSR_IDX_CAL, 32'h0, {25'h0, cal});
			apb(1'b0, `RSR_IDX_TXFILL, 32'h0, {25'h0, txu, txc});
			apb(1'b0, `RSR_IDX_RXFILL, 32'h0, {25'h0, rxo, rxc});
		end
		$display("test timer and fill done");

		// inversion on both outputs must not reach the readback bits
		apb(1'b1, `RSR_IDX_CTRL, 32'h7, 33'h0);
		@(posedge core_clk);
		chk(legacy, 1'b1);
		repeat (6) begin
			@(posedge core_clk);
			{pqm, sff, out2, out0, csA, ccA} <= 6'($urandom());
			if (crcExp) begin
				rxEnter <= 1'b1;
				crcExp = 1'b0;
			end else begin
				crcDone <= 1'b1;
				crcPass <= 1'b1;
				crcExp = 1'b1;
			end
			@(posedge core_clk);
			{rxEnter, crcDone} <= 2'h0;
			repeat (6) @(posedge core_clk);
			// lock is never judged from an output readback bit
			pe = {25'h0, crcExp, csA, pqm, ccA, sff, out2, 1'b0, out0};
			apb(1'b0, `RSR_IDX_PKT, 32'h0, pe);
			apb(1'b0, `RSR_IDX_PKT, 32'h0, pe);
			chk(pin0, ~out0);
			chk(pin2, ~out2);
		end
		apb(1'b1, `RSR_IDX_CTRL, 32'h0, 33'h0);
		@(posedge core_clk);
		chk(legacy, 1'b0);
		// a fresh passing verdict must stay hidden outside legacy mode
		{crcDone, crcPass} <= 2'h3;
		@(posedge core_clk);
		crcDone <= 1'b0;
		pe[7] = 1'b0;
		apb(1'b0, `RSR_IDX_PKT, 32'h0, pe);
		$display("test packet status done");

		for (int i = 0; i < 6; i++)
			apb(1'b1, `RSR_IDX_WAKE_HI + 8'(i), 32'hff, 33'h0);
		apb(1'b0, `RSR_IDX_CAL, 32'h0, {25'h0, cal});
		apb(1'b0, `RSR_IDX_TXFILL, 32'h0, {25'h0, txu, txc});
		apb(1'b0, 8'h50, 32'h0, {1'b1, 32'h0});
		// a write without the low byte strobe must not land
		pstrb <= 4'he;
		apb(1'b1, `RSR_IDX_IRQ_MASK, 32'hf, 33'h0);
		pstrb <= 4'hf;
		apb(1'b0, `RSR_IDX_IRQ_MASK, 32'h0, 33'h0);
		$display("test read-only and unmapped done");

		@(posedge core_clk);
		sff <= 1'b0;
		apb(1'b1, `RSR_IDX_IRQ_STAT, 32'hf, 33'h0);
		@(posedge core_clk);
		sff <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk(irq, 1'b0);
		apb(1'b0, `RSR_IDX_IRQ_STAT, 32'h0, 33'h2);
		apb(1'b1, `RSR_IDX_IRQ_MASK, 32'h2, 33'h0);
		repeat (2) @(posedge core_clk);
		chk(irq, 1'b1);
		apb(1'b1, `RSR_IDX_IRQ_STAT, 32'h2, 33'h0);
		repeat (2) @(posedge core_clk);
		chk(irq, 1'b0);
		apb(1'b0, `RSR_IDX_IRQ_STAT, 32'h0, 33'h0);
		$display("test interrupt done");

		// frozen by the clock enable, the pin keeps its old level
		@(posedge core_clk);
		ce <= 1'b0;
		out0 <= ~out0;
		repeat (3) @(posedge core_clk);
		chk(pin0, ~out0);
		ce <= 1'b1;
		repeat (2) @(posedge core_clk);
		chk(pin0, out0);
		$display("test clock enable done");

		// a reset in mid-run drops the mask written above
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		apb(1'b0, `RSR_IDX_IRQ_MASK, 32'h0, 33'h0);
		chk(irq, 1'b0);
		$display("test mid-run reset done");
		repeat (3) @(posedge core_clk);
		completeRun();
	end
endmodule : rsr_regs_tb

`default_nettype wire

// ===== verilog/rsr_params.svh
`ifndef RSR_PARAMS_SVH
`define RSR_PARAMS_SVH

// register indices; byte address is four times the index
`define RSR_IDX_WAKE_HI 8'h36
`define RSR_IDX_WAKE_LO 8'h37
`define RSR_IDX_PKT 8'h38
`define RSR_IDX_CAL 8'h39
`define RSR_IDX_TXFILL 8'h3a
`define RSR_IDX_RXFILL 8'h3b
`define RSR_IDX_CTRL 8'h40
`define RSR_IDX_IRQ_STAT 8'h41
`define RSR_IDX_IRQ_MASK 8'h42
`define RSR_IDX_MSB 9
`define RSR_IDX_LSB 2

// packet status bit positions
`define RSR_PKT_CRC 7
`define RSR_PKT_CS 6
`define RSR_PKT_PQT 5
`define RSR_PKT_CCA 4
`define RSR_PKT_SYNC 3
`define RSR_PKT_OUT2 2
`define RSR_PKT_OUT0 0

// control register
`define RSR_CTRL_W 3
`define RSR_CTRL_LEGACY 0
`define RSR_CTRL_INV0 1
`define RSR_CTRL_INV2 2
`define RSR_CTRL_RST 3'h0

// interrupt events
`define RSR_EVT_W 4
`define RSR_EVT_CRC 0
`define RSR_EVT_SYNC 1
`define RSR_EVT_TXUND 2
`define RSR_EVT_RXOVR 3
`define RSR_MASK_RST 4'h0

`define RSR_TIMER_W 16
`define RSR_BYTE_W 8
`define RSR_COUNT_W 7
`endif

// ===== verilog/rsr_pkg.sv
`default_nettype none
`include "rsr_params.svh"

package rsr_pkg;
	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic irq;
		logic crcOk;
		logic [`RSR_CTRL_W-1:0] ctrl;
		logic [`RSR_EVT_W-1:0] irqStat;
		logic [`RSR_EVT_W-1:0] irqMask;
		logic [`RSR_EVT_W-1:0] evtPrev;
		logic outZeroPin;
		logic outTwoPin;
	} rsr_state_t;
endpackage : rsr_pkg

`default_nettype wire

// ===== verilog/rsr_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "rsr_params.svh"

module rsr_regs #(
	parameter int ADDR_W = 12
) (
	// clocking
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// radio core, same clock
	input wire logic [`RSR_TIMER_W-1:0] wakeTimer,
	input wire logic crcCheckDone,
	input wire logic crcPass,
	input wire logic rxEnter,
	input wire logic preambleQualityMet,
	input wire logic syncFoundFlag,
	input wire logic generalOutputTwo,
	input wire logic generalOutputZero,
	input wire logic [7:0] synthCalDac,
	input wire logic [`RSR_COUNT_W-1:0] txQueueCount,
	input wire logic txQueueUnderrun,
	input wire logic [`RSR_COUNT_W-1:0] rxQueueCount,
	input wire logic rxQueueOverrun,
	// analog detectors, asynchronous
	input wire logic carrierSenseAsync,
	input wire logic clearChannelAsync,
	// outputs
	output logic irq,
	output logic legacyCrcModeEnable,
	output logic generalOutputTwoPin,
	output logic generalOutputZeroPin
);
	import rsr_pkg::*;

	if (ADDR_W < `RSR_IDX_MSB + 1) begin : g_chk
		$error("rsr_regs: ADDR_W too narrow for the register map");
	end

	rsr_state_t st;
	rsr_state_t next_st;
	logic [1:0] detSync;
	logic carrierSense;
	logic clearChannelFlag;
	logic [7:0] idx;
	logic [7:0] rdByte;
	logic hit;
	logic access;
	logic wrTake;
	logic [`RSR_EVT_W-1:0] evtLvl;
	logic [`RSR_EVT_W-1:0] evtRise;
	logic [`RSR_EVT_W-1:0] statClr;

	////////////////////////////////////////////////////////////////////////
	// detector inputs cross in through four flops
	rsr_sync #(
		.WIDTH(2)
	) u_sync (
		.core_clk(core_clk),
		.rst(rst),
		.ce(ce),
		.asyncIn({clearChannelAsync, carrierSenseAsync}),
		.syncOut(detSync)
	);
	assign carrierSense = detSync[0];
	assign clearChannelFlag = detSync[1];

	////////////////////////////////////////////////////////////////////////
	// read decode
	assign idx = paddr[`RSR_IDX_MSB:`RSR_IDX_LSB];

	always_comb begin
		rdByte = 8'h00;
		hit = 1'b1;
		unique case (idx)
			`RSR_IDX_WAKE_HI:
				rdByte = wakeTimer[`RSR_TIMER_W-1:`RSR_BYTE_W];
			`RSR_IDX_WAKE_LO:
				rdByte = wakeTimer[`RSR_BYTE_W-1:0];
			`RSR_IDX_PKT: begin
				// crc result only shown in legacy mode; bit 1 stays zero
				rdByte[`RSR_PKT_CRC] = st.crcOk &
					st.ctrl[`RSR_CTRL_LEGACY];
				rdByte[`RSR_PKT_CS] = carrierSense;
				rdByte[`RSR_PKT_PQT] = preambleQualityMet;
				rdByte[`RSR_PKT_CCA] = clearChannelFlag;
				rdByte[`RSR_PKT_SYNC] = syncFoundFlag;
				// raw levels, ahead of the pin inverters
				rdByte[`RSR_PKT_OUT2] = generalOutputTwo;
				rdByte[`RSR_PKT_OUT0] = generalOutputZero;
			end
			`RSR_IDX_CAL: rdByte = synthCalDac;
			`RSR_IDX_TXFILL: rdByte = {txQueueUnderrun,
				txQueueCount};
			`RSR_IDX_RXFILL: rdByte = {rxQueueOverrun,
				rxQueueCount};
			`RSR_IDX_CTRL: rdByte[`RSR_CTRL_W-1:0] = st.ctrl;
			`RSR_IDX_IRQ_STAT: rdByte[`RSR_EVT_W-1:0] = st.irqStat;
			`RSR_IDX_IRQ_MASK: rdByte[`RSR_EVT_W-1:0] = st.irqMask;
			default: hit = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// next state
	assign access = psel & penable;
	// a write lands only at the edge where pready is seen high
	assign wrTake = access & st.pready & pwrite & hit & pstrb[0];
	assign evtLvl = {rxQueueOverrun, txQueueUnderrun, syncFoundFlag,
		st.crcOk};
	assign evtRise = evtLvl & ~st.evtPrev;
	assign statClr = (wrTake && idx == `RSR_IDX_IRQ_STAT) ?
		pwdata[`RSR_EVT_W-1:0] : '0;

	always_comb begin
		next_st = st;
		// one wait state: answer is registered, then released
		if (access & ~st.pready) begin
			next_st.pready = 1'b1;
			next_st.pslverr = ~hit;
			next_st.prdata = (hit & ~pwrite) ? {24'h0, rdByte} : 32'h0;
		end else begin
			next_st.pready = 1'b0;
			next_st.pslverr = 1'b0;
		end
		// receiver entry outranks a simultaneous crc verdict
		if (rxEnter) begin
			next_st.crcOk = 1'b0;
		end else if (crcCheckDone) begin
			next_st.crcOk = crcPass;
		end
		// status indices are not writable: only these three take data
		if (wrTake && idx == `RSR_IDX_CTRL) begin
			next_st.ctrl = pwdata[`RSR_CTRL_W-1:0];
		end
		if (wrTake && idx == `RSR_IDX_IRQ_MASK) begin
			next_st.irqMask = pwdata[`RSR_EVT_W-1:0];
		end
		// set wins over write-one-to-clear in the same cycle
		next_st.irqStat = (st.irqStat & ~statClr) | evtRise;
		next_st.evtPrev = evtLvl;
		next_st.irq = |(next_st.irqStat & next_st.irqMask);
		next_st.outZeroPin = generalOutputZero ^
			next_st.ctrl[`RSR_CTRL_INV0];
		next_st.outTwoPin = generalOutputTwo ^
			next_st.ctrl[`RSR_CTRL_INV2];
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st <= '0;
			st.ctrl <= `RSR_CTRL_RST;
			st.irqMask <= `RSR_MASK_RST;
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign irq = st.irq;
	assign legacyCrcModeEnable = st.ctrl[`RSR_CTRL_LEGACY];
	assign generalOutputTwoPin = st.outTwoPin;
	assign generalOutputZeroPin = st.outZeroPin;

	////////////////////////////////////////////////////////////////////////
	// checks; a frozen clock enable would stretch every window
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst || !ce);

	logic rdEnd;
	logic [7:0] rdIdx;
	assign rdEnd = pready & psel & penable & ~pwrite & ~pslverr;
	assign rdIdx = idx;

	wake_hi_read_a: assert property (
		rdEnd && rdIdx == `RSR_IDX_WAKE_HI |->
		prdata == {24'h0, $past(wakeTimer[15:8])})
		else $error("wake timer high byte read mismatch");

	wake_lo_read_a: assert property (
		rdEnd && rdIdx == `RSR_IDX_WAKE_LO |->
		prdata == {24'h0, $past(wakeTimer[7:0])})
		else $error("wake timer low byte read mismatch");

	crc_gate_a: assert property (
		rdEnd && rdIdx == `RSR_IDX_PKT && !legacyCrcModeEnable
		&& $stable(legacyCrcModeEnable) |->
		!prdata[`RSR_PKT_CRC])
		else $error("crc bit shown outside legacy mode");

	crc_clear_a: assert property (
		rxEnter ##1 ce |-> !st.crcOk)
		else $error("crc flag survived receiver entry");

	pkt_flags_a: assert property (
		rdEnd && rdIdx == `RSR_IDX_PKT |->
		prdata[`RSR_PKT_PQT] == $past(preambleQualityMet) &&
		prdata[`RSR_PKT_SYNC] == $past(syncFoundFlag) &&
		prdata[`RSR_PKT_CS] == $past(carrierSense))
		else $error("packet status flags mismatch");

	out_two_raw_a: assert property (
		rdEnd && rdIdx == `RSR_IDX_PKT |->
		prdata[`RSR_PKT_OUT2] == $past(generalOutputTwo))
		else $error("output two readback not raw");

	out_zero_raw_a: assert property (
		rdEnd && rdIdx == `RSR_IDX_PKT |->
		prdata[`RSR_PKT_OUT0] == $past(generalOutputZero))
		else $error("output zero readback not raw");

	cal_dac_read_a: assert property (
		rdEnd && rdIdx == `RSR_IDX_CAL |->
		prdata == {24'h0, $past(synthCalDac)})
		else $error("calibration dac read mismatch");

	tx_fill_read_a: assert property (
		rdEnd && rdIdx == `RSR_IDX_TXFILL |->
		prdata[7:0] == {$past(txQueueUnderrun), $past(txQueueCount)})
		else $error("tx fill status mismatch");

	rx_fill_read_a: assert property (
		rdEnd && rdIdx == `RSR_IDX_RXFILL |->
		prdata[7:0] == {$past(rxQueueOverrun), $past(rxQueueCount)})
		else $error("rx fill status mismatch");

	reserved_zero_a: assert property (
		rdEnd |-> prdata[31:8] == 24'h0 &&
		!(rdIdx == `RSR_IDX_PKT && prdata[1]))
		else $error("reserved bits not zero");

	status_wr_ign_a: assert property (
		psel && penable && pwrite && pready && idx >= `RSR_IDX_WAKE_HI
		&& idx <= `RSR_IDX_RXFILL |=>
		$stable(legacyCrcModeEnable) && $stable(st.irqMask))
		else $error("write to status register changed state");

	apb_wait_a: assert property (
		psel && penable && !pready |=> pready ##1 !pready)
		else $error("apb answer not after one wait state");

	irq_level_a: assert property (
		|(st.irqStat & st.irqMask) |-> irq)
		else $error("irq low with unmasked status set");

	ready_pulse_a: assert property (
		pready |=> !pready)
		else $error("pready held for more than one cycle");

	err_with_ready_a: assert property (
		pslverr |-> pready)
		else $error("pslverr without pready");

	unmapped_err_a: assert property (
		psel && penable && pready && !hit |-> pslverr)
		else $error("unmapped index answered without error");

	write_data_zero_a: assert property (
		psel && penable && pready && pwrite |-> prdata == 32'h0)
		else $error("read data not zero on a write");

	mask_write_a: assert property (
		wrTake && idx == `RSR_IDX_IRQ_MASK |=>
		st.irqMask == $past(pwdata[`RSR_EVT_W-1:0]))
		else $error("interrupt mask write lost");

	crc_verdict_a: assert property (
		crcCheckDone && !rxEnter |=> st.crcOk == $past(crcPass))
		else $error("crc flag did not take the verdict");

	stat_set_a: assert property (
		|evtRise |=> (st.irqStat & $past(evtRise)) == $past(evtRise))
		else $error("interrupt status event lost");

	stat_clear_a: assert property (
		statClr != '0 |=>
		(st.irqStat & $past(statClr) & ~$past(evtRise)) == '0)
		else $error("write one to clear failed");

	// the pins follow the raw level one cycle late, through the inverters
	pin_zero_inv_a: assert property (
		$past(ce) && !$past(rst) |->
		generalOutputZeroPin ==
		($past(generalOutputZero) ^ st.ctrl[`RSR_CTRL_INV0]))
		else $error("output zero pin not raw level with inversion");

	pin_two_inv_a: assert property (
		$past(ce) && !$past(rst) |->
		generalOutputTwoPin ==
		($past(generalOutputTwo) ^ st.ctrl[`RSR_CTRL_INV2]))
		else $error("output two pin not raw level with inversion");

	crc_event_c: cover property (crcCheckDone && crcPass ##1 st.crcOk);
	status_read_c: cover property (rdEnd && rdIdx == `RSR_IDX_PKT);
	irq_raise_c: cover property (!irq ##1 irq);
	unmapped_c: cover property (pready && pslverr);
endmodule : rsr_regs

`default_nettype wire

// ===== verilog/rsr_sync.sv
`timescale 1ns/1ps
`default_nettype none

module rsr_sync #(
	parameter int WIDTH = 2
) (
	// clocking
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	// levels
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] lvl;
	} rsr_sync_st_t;

	rsr_sync_st_t st;
	rsr_sync_st_t next_st;

	if (WIDTH < 1) begin : g_chk
		$error("rsr_sync: WIDTH must be at least 1");
	end

	// s1 feeds s2 only; a change is accepted once s2 and s3 agree
	always_comb begin
		next_st = st;
		next_st.s1 = asyncIn;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		for (int i = 0; i < WIDTH; i++) begin
			if (st.s2[i] == st.s3[i]) begin
				next_st.lvl[i] = st.s3[i];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign syncOut = st.lvl;
endmodule : rsr_sync

`default_nettype wire
